// File: dv/flash_array_model.sv
// flash array behind the block: fixed read lanes, counts of strobes
// assumes strobes are one-cycle pulses on the system clock
`timescale 1ns/100ps
module flash_array_model (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         array_prog,
  input  wire logic         array_erase,
  input  wire logic         array_full_erase,
  input  wire logic [8:0]   array_page,
  output logic [127:0]      array_rdata,
  output logic [15:0]       n_prog,
  output logic [15:0]       n_erase,
  output logic [15:0]       n_full,
  output logic [8:0]        last_page
);
  // distinct lanes so a wrong lane pick shows up
  assign array_rdata = {32'hC0DE_0003, 32'hC0DE_0002, 32'hC0DE_0001, 32'hC0DE_0000};
  always_ff @(posedge clock) begin
    if (rst) begin
      n_prog <= 16'h0;
      n_erase <= 16'h0;
      n_full <= 16'h0;
    end else begin
      n_prog <= n_prog + 16'(array_prog);
      n_erase <= n_erase + 16'(array_erase);
      n_full <= n_full + 16'(array_full_erase);
    end
  end
  always_ff @(posedge clock) begin
    if (array_prog || array_erase) last_page <= array_page;
  end
endmodule : flash_array_model

// File: dv/memmap_checker.sv
// concurrent checks on the decoder and protection block ports
// assumes bind onto memmap_boot_protect, one clock domain
`timescale 1ns/100ps
module memmap_checker
  import memmap_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] sys_addr,
  input wire logic        sys_valid,
  input wire logic [3:0]  sys_target,
  input wire logic        sys_abort,
  input wire logic        test_mode_input,
  input wire logic        external_clock_input,
  input wire logic        force_wakeup_input,
  input wire logic        fast_mode,
  input wire logic        ice_flash_req,
  input wire logic        ice_flash_deny,
  input wire logic        array_prog,
  input wire logic        array_erase,
  input wire logic        lock_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready in access");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_bad_offset: assert property (psel && !penable && paddr[31:8] != 24'h0 |=> pslverr && pready)
    else $error("no slave error");
  a_flash_map: assert property (sys_valid && sys_addr[31:20] == 12'h001 && sys_addr[19:0] < 20'h2_0000
    |=> sys_target == SEL_FLASH && !sys_abort) else $error("flash not decoded");
  a_rom_map: assert property (sys_valid && sys_addr[31:20] == 12'h004 && sys_addr[19:0] < 20'h0_3000
    |=> sys_target == SEL_ROM) else $error("rom not decoded");
  a_backup_map: assert property (sys_valid && sys_addr[31:20] == 12'h003 && sys_addr[19:0] < 20'h0_0800
    |=> sys_target == SEL_SRAM) else $error("backup not decoded");
  a_core_map: assert property (sys_valid && sys_addr[31:12] == 20'h00200
    |=> sys_target == SEL_SRAM && !sys_abort) else $error("core not decoded");
  a_undef_abort: assert property (sys_valid && sys_addr >= 32'h0050_0000 && sys_addr < INT_LIMIT
    |=> sys_abort && sys_target == SEL_NONE) else $error("no abort");
  a_fast_entry: assert property (1'b1 |=>
    fast_mode == $past(test_mode_input && external_clock_input && !force_wakeup_input))
    else $error("fast mode wrong");
  a_deny_cause: assert property (ice_flash_deny |-> $past(ice_flash_req)) else $error("deny uncaused");
  a_irq_no_strobe: assert property (lock_irq |-> !array_prog && !array_erase) else $error("strobe on lock");
  c_irq: cover property (lock_irq);
  c_abort: cover property (sys_abort);
  c_deny: cover property (ice_flash_deny);
  c_core: cover property (sys_valid && sys_addr[31:12] == 20'h00200);
endmodule : memmap_checker

bind memmap_boot_protect memmap_checker u_memmap_checker (.clock, .rst, .paddr, .psel, .penable, .pready,
  .pslverr, .sys_addr, .sys_valid, .sys_target, .sys_abort, .test_mode_input, .external_clock_input,
  .force_wakeup_input, .fast_mode, .ice_flash_req, .ice_flash_deny, .array_prog, .array_erase, .lock_irq);

// File: dv/tb.sv
// self-checking bench for the decoder, boot selection and flash protection
// assumes the array model beside the block and the checker bound in its file
`timescale 1ns/100ps
module tb;
  import memmap_pkg::*;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sys_valid = 0, slow_tick = 0;
  logic        erase_pin = 0, test_mode_input = 0, external_clock_input = 0;
  logic        force_wakeup_input = 0, ice_flash_req = 0;
  logic [31:0] paddr = 0, pwdata = 0, sys_addr = 0, q;
  logic        e;
  logic [31:0] prdata, sys_offset, flash_rword;
  logic        pready, pslverr, sys_abort, fast_mode, ice_flash_deny;
  logic        array_prog, array_erase, array_full_erase, lock_irq;
  logic [3:0]  sys_target;
  logic [8:0]  array_page, last_page;
  logic [127:0] array_rdata;
  logic [15:0] n_prog, n_erase, n_full;
  int          num_errors = 0, n_tests = 0, n_irq = 0, cyc = 0;
  // rows: {expected target, address}, reset state with boot bit clear
  logic [35:0] rows [8] = '{{SEL_ROM, 32'h0000_0100}, {SEL_FLASH, 32'h0010_0040}, {SEL_SRAM, 32'h0020_0010},
    {SEL_SRAM, 32'h0030_0010}, {SEL_SRAM, 32'h002F_F010}, {SEL_ROM, 32'h0040_2FFC},
    {SEL_NONE, 32'h0050_0000}, {SEL_NONE, 32'h0FFF_FFFC}};
  memmap_boot_protect #(.CAL_DEFAULT(32'h0000_5A5A)) u_memmap_boot_protect (.clock, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sys_addr, .sys_valid, .sys_target, .sys_offset,
    .sys_abort, .slow_tick, .erase_pin, .test_mode_input, .external_clock_input, .force_wakeup_input,
    .fast_mode, .ice_flash_req, .ice_flash_deny, .array_rdata, .flash_rword, .array_prog, .array_erase,
    .array_full_erase, .array_page, .lock_irq);
  flash_array_model u_flash_array_model (.clock, .rst, .array_prog, .array_erase, .array_full_erase,
    .array_page, .array_rdata, .n_prog, .n_erase, .n_full, .last_page);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (lock_irq === 1'b1) n_irq <= n_irq + 1;
    if (cyc == 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    check(q, exp);
  endtask : rd
  task automatic cmd(input logic [3:0] c, input logic [8:0] g, input logic [1:0] s);
    apb(1, REG_CMD, {6'h00, s, 7'h00, g, 4'h0, c});
  endtask : cmd
  task automatic dec(input logic [31:0] a);
    @(posedge clock);
    sys_addr <= a;
    sys_valid <= 1;
    @(posedge clock);
    sys_valid <= 0;
    #1;
  endtask : dec
  initial begin
    repeat (10) @(posedge clock);
    rst <= 0;
    rd(REG_LOCK, 0);
    rd(REG_GPBITS, 0);
    rd(REG_CAL, 32'h0000_5A5A);
    apb(0, REG_DESC, 0);
    check(q[31:8], {16'd512, 8'd16});
    apb(1, REG_WBUF, 32'h0800_1234);
    rd(REG_WBUF, 32'h0800_1234);
    for (int i = 0; i < 8; i++) begin
      dec(rows[i][31:0]);
      check(sys_target, rows[i][35:32]);
      check(sys_abort, rows[i][35:32] == SEL_NONE);
    end
    dec(FLASH_BASE + 32'h8);
    check(flash_rword, 32'hC0DE_0002);
    cmd(CMD_SGP, 1, SRC_CPU);
    dec(0);
    check(sys_target, SEL_FLASH);
    apb(1, REG_CTRL, 1);
    dec(32'h10);
    check(sys_target, SEL_SRAM);
    check(sys_offset, BACKUP_SIZE + 32'h10);
    dec(CORE_BASE + 32'h10);
    check(sys_target, SEL_SRAM);
    check(sys_offset, BACKUP_SIZE + 32'h10);
    dec(32'h2000);
    check(sys_abort, 1);
    cmd(CMD_SLOCK, 0, SRC_CPU);
    rd(REG_LOCK, 1);
    cmd(CMD_PROG, 5, SRC_CPU);
    cmd(CMD_ERASE, 5, SRC_CPU);
    cmd(CMD_PROG, 40, SRC_CPU);
    repeat (2) @(posedge clock);
    check(n_irq, 2);
    check({n_prog, n_erase}, {16'd1, 16'd0});
    check(last_page, 40);
    rd(REG_STATUS, 2);
    cmd(CMD_CLOCK, 0, SRC_CPU);
    rd(REG_LOCK, 0);
    cmd(CMD_SGP, 0, SRC_CPU);
    rd(REG_GPBITS, 3);
    ice_flash_req <= 1;
    repeat (2) @(posedge clock);
    check(ice_flash_deny, 1);
    ice_flash_req <= 0;
    cmd(CMD_PROG, 40, SRC_FAST);
    rd(REG_STATUS, 4);
    check(n_prog, 1);
    cmd(CMD_CGP, 0, SRC_CPU);
    rd(REG_GPBITS, 3);
    cmd(CMD_SLOCK, 0, SRC_CPU);
    // slow tick every clock keeps the debounce counts short
    slow_tick <= 1;
    erase_pin <= 1;
    repeat (ERASE_IGN_CYC - 10) @(posedge clock);
    erase_pin <= 0;
    rd(REG_LOCK, 1);
    erase_pin <= 1;
    repeat (ERASE_ACT_CYC + 10) @(posedge clock); // held past the action count
    rd(REG_LOCK, 0);
    rd(REG_GPBITS, 1);
    cmd(CMD_FULL, 0, SRC_CPU);
    rd(REG_GPBITS, 0);
    erase_pin <= 0;
    rd(REG_CAL, 32'h0000_5A5A);
    test_mode_input <= 1;
    external_clock_input <= 1;
    repeat (2) @(posedge clock);
    check(fast_mode, 1);
    force_wakeup_input <= 1;
    repeat (2) @(posedge clock);
    check(fast_mode, 0);
    apb(0, 32'h20, 0);
    check(e, 1);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    dec(0);
    check(sys_target, SEL_ROM);
    print_verdict();
  end
endmodule : tb

// File: logic/memmap_boot_protect.sv
// internal memory decoder, remap, boot selection and flash protection policy
// assumes an APB master, a slow-clock enable pulse on the system clock, and the flash array behind
`timescale 1ns/100ps
module memmap_boot_protect
  import memmap_pkg::*;
#(
  parameter int           REGIONS     = 16,
  parameter int           PAGES       = 512,
  parameter logic [31:0]  CAL_DEFAULT = 32'h0000_0000
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [31:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [31:0]  sys_addr,
  input  wire logic         sys_valid,
  output logic [3:0]        sys_target,
  output logic [31:0]       sys_offset,
  output logic              sys_abort,
  input  wire logic         slow_tick,
  input  wire logic         erase_pin,
  input  wire logic         test_mode_input,
  input  wire logic         external_clock_input,
  input  wire logic         force_wakeup_input,
  output logic              fast_mode,
  input  wire logic         ice_flash_req,
  output logic              ice_flash_deny,
  input  wire logic [127:0] array_rdata,
  output logic [31:0]       flash_rword,
  output logic              array_prog,
  output logic              array_erase,
  output logic              array_full_erase,
  output logic [8:0]        array_page,
  output logic              lock_irq
);
  localparam logic [31:0] DESC_WORD = {16'(PAGES), 8'(REGIONS), 8'(PAGE_BYTES / 32)};

  logic [REGIONS-1:0] lock_bits; // one bit per 8 Kbyte region
  logic [1:0]         general_nonvolatile_bit;
  logic               remapped;
  logic               lock_error;
  logic               sec_refused;
  logic [31:0]        wbuf [WBUF_WORDS];
  logic [31:0]        wbuf_last;
  logic [15:0]        erase_cnt;
  logic               erase_valid;
  logic               erase_seen;
  logic [31:0]        next_rdata;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    in_range = (a >= base) && (a < base + size);
  endfunction : in_range

  function automatic logic [3:0] region_of(input logic [8:0] page);
    region_of = 4'(page / 9'(REGION_PAGES));
  endfunction : region_of

  // address decode, registered
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_target <= SEL_NONE;
      sys_offset <= 32'h0000_0000;
      sys_abort  <= 1'b0;
    end else begin
      sys_abort <= 1'b0;
      if (sys_valid) begin
        if (sys_addr < AREA_SIZE) begin
          sys_offset <= sys_addr;
          if (remapped) begin
            sys_target <= SEL_SRAM;
            sys_offset <= sys_addr + BACKUP_SIZE; // alias lands on the same store words as the core base
          end else if (general_nonvolatile_bit[BOOT_BIT]) begin
            sys_target <= SEL_FLASH;
          end else begin
            sys_target <= SEL_ROM;
          end
          if (remapped && !in_range(sys_addr, ZERO_BASE, CORE_SIZE)) begin
            sys_target <= SEL_NONE;
            sys_abort  <= 1'b1;
          end
        end else if (in_range(sys_addr, FLASH_BASE, FLASH_SIZE)) begin
          sys_target <= SEL_FLASH;
          sys_offset <= sys_addr - FLASH_BASE;
        end else if (in_range(sys_addr, CORE_BASE, CORE_SIZE)) begin
          sys_target <= SEL_SRAM;
          sys_offset <= sys_addr - CORE_BASE + BACKUP_SIZE;
        end else if (in_range(sys_addr, CONTIG_BASE, CORE_SIZE + BACKUP_SIZE)) begin
          // contiguous window: core then backup, both offsets into one 6 Kbyte store
          sys_target <= SEL_SRAM;
          sys_offset <= sys_addr - CONTIG_BASE + BACKUP_SIZE;
        end else if (in_range(sys_addr, BACKUP_BASE, BACKUP_SIZE)) begin
          sys_target <= SEL_SRAM;
          sys_offset <= sys_addr - BACKUP_BASE + CORE_SIZE + BACKUP_SIZE;
        end else if (in_range(sys_addr, ROM_BASE, ROM_SIZE)) begin
          sys_target <= SEL_ROM;
          sys_offset <= sys_addr - ROM_BASE;
        end else begin
          sys_target <= SEL_NONE;
          sys_offset <= 32'h0000_0000;
          sys_abort  <= (sys_addr < INT_LIMIT);
        end
      end
    end
  end

  // erase pin debounce counted in slow clock ticks
  always_ff @(posedge clock) begin
    if (rst) begin
      erase_cnt   <= 16'h0000;
      erase_valid <= 1'b0;
      erase_seen  <= 1'b0;
    end else begin
      erase_valid <= 1'b0;
      if (!erase_pin) begin
        erase_cnt  <= 16'h0000;
        erase_seen <= 1'b0;
      end else if (slow_tick && !erase_seen) begin
        erase_cnt <= erase_cnt + 16'h0001;
        if (erase_cnt >= 16'(ERASE_ACT_CYC - 1)) begin
          erase_valid <= 1'b1;
          erase_seen  <= 1'b1;
        end
      end
    end
  end

  // fast programming entry is a plain level decode of the straps
  always_ff @(posedge clock) begin
    if (rst) begin
      fast_mode <= 1'b0;
    end else begin
      fast_mode <= test_mode_input && external_clock_input && !force_wakeup_input;
    end
  end

  // debug port flash access refused while secured
  always_ff @(posedge clock) begin
    if (rst) begin
      ice_flash_deny <= 1'b0;
    end else begin
      ice_flash_deny <= ice_flash_req && general_nonvolatile_bit[SEC_BIT];
    end
  end

  // a refused transfer (upper address bits set) must not touch any register
  wire        apb_wr  = psel && penable && pwrite && (paddr[31:8] == 24'h000000);
  wire        apb_rd  = psel && penable && !pwrite && (paddr[31:8] == 24'h000000);
  wire        cmd_wr  = apb_wr && (paddr[7:0] == REG_CMD) && (paddr[31:8] == 24'h000000);
  wire [3:0]  cmd     = pwdata[CMD_LSB +: 4];
  wire [8:0]  cmd_arg = pwdata[ARG_LSB +: 9];
  wire [1:0]  cmd_src = pwdata[PORT_LSB +: 2];
  wire        secured = general_nonvolatile_bit[SEC_BIT];
  wire        src_ext = (cmd_src == SRC_ICE) || (cmd_src == SRC_FAST);
  wire        page_ok = 32'(cmd_arg) < 32'(PAGES);
  wire        locked  = page_ok && lock_bits[region_of(cmd_arg)];

  // command execution: protection, general bits, lock bits, array strobes
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_bits               <= '0;
      general_nonvolatile_bit <= 2'b00;
      remapped                <= 1'b0;
      lock_error              <= 1'b0;
      sec_refused             <= 1'b0;
      lock_irq                <= 1'b0;
      array_prog              <= 1'b0;
      array_erase             <= 1'b0;
      array_full_erase        <= 1'b0;
      array_page              <= 9'h000;
    end else begin
      array_prog       <= 1'b0;
      array_erase      <= 1'b0;
      array_full_erase <= 1'b0;
      lock_irq         <= 1'b0;
      // status flags clear on status read; a same-cycle event wins below
      if (apb_rd && paddr[7:0] == REG_STATUS) begin
        lock_error  <= 1'b0;
        sec_refused <= 1'b0;
      end
      if (apb_wr && paddr[7:0] == REG_CTRL && pwdata[0]) begin
        remapped <= 1'b1;
      end
      if (cmd_wr) begin
        if (src_ext && secured && cmd != CMD_FULL) begin
          sec_refused <= 1'b1;
        end else begin
          case (cmd)
            CMD_PROG, CMD_ERASE: begin
              if (locked) begin
                lock_error <= 1'b1;
                lock_irq   <= 1'b1;
              end else if (page_ok) begin
                array_prog  <= (cmd == CMD_PROG);
                array_erase <= (cmd == CMD_ERASE);
                array_page  <= cmd_arg;
              end
            end
            CMD_FULL: begin
              if (|lock_bits) begin
                lock_error <= 1'b1;
                lock_irq   <= 1'b1;
              end else begin
                array_full_erase <= 1'b1;
                if (erase_pin) begin
                  general_nonvolatile_bit[SEC_BIT] <= 1'b0;
                end
              end
            end
            CMD_SLOCK: begin
              if (page_ok) begin
                lock_bits[region_of(cmd_arg)] <= 1'b1;
              end
            end
            CMD_CLOCK: begin
              if (page_ok) begin
                lock_bits[region_of(cmd_arg)] <= 1'b0;
              end
            end
            CMD_SGP: begin
              general_nonvolatile_bit[cmd_arg[0]] <= 1'b1;
            end
            CMD_CGP: begin
              if (cmd_arg[0] == 1'(BOOT_BIT)) begin
                general_nonvolatile_bit[BOOT_BIT] <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (erase_valid) begin
        lock_bits                          <= '0;
        general_nonvolatile_bit[BOOT_BIT]  <= 1'b0;
      end
    end
  end

  // write buffer, loaded one 32-bit word per access
  always_ff @(posedge clock) begin
    if (rst) begin
      wbuf_last <= 32'h0000_0000;
    end else if (apb_wr && paddr[7:0] == REG_WBUF) begin
      wbuf[pwdata[31:27]] <= {5'h00, pwdata[26:0]};
      wbuf_last <= pwdata;
    end
  end

  // 128-bit array word narrowed by the low address bits
  always_ff @(posedge clock) begin
    if (rst) begin
      flash_rword <= 32'h0000_0000;
    end else begin
      flash_rword <= array_rdata[32 * sys_addr[3:2] +: 32];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr[7:0])
      REG_CTRL:   next_rdata = {31'h0, remapped};
      REG_STATUS: next_rdata = {29'h0, sec_refused, lock_error, fast_mode};
      REG_LOCK:   next_rdata = 32'(lock_bits);
      REG_GPBITS: next_rdata = {30'h0, general_nonvolatile_bit};
      REG_DESC:   next_rdata = DESC_WORD;
      REG_WBUF:   next_rdata = wbuf_last;
      REG_CAL:    next_rdata = CAL_DEFAULT;
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  // APB slave: no wait state, data registered
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[31:8] != 24'h000000 || paddr[7:0] > REG_CAL);
      prdata  <= next_rdata;
    end
  end
endmodule : memmap_boot_protect

// File: logic/memmap_pkg.sv
// constants for the internal memory decoder, boot selection and flash protection
// assumes one system clock; APB register slave and flash array live next to it
// Function
// - before remap core SRAM decodes only at its own base and in the contiguous window
// - backup SRAM always decodes at its base
// - after remap core SRAM also aliases at address zero
// - core and backup SRAM appear as one contiguous 6 Kbyte range
// - ROM always mapped at its base, 12 Kbytes
// - flash always mapped at its base
// - before remap zero aliases flash if boot bit set, else ROM
// - two general bits: bit 0 security, bit 1 boot select, own commands
// - valid erase pin clears boot select bit
// - one lock bit per 8 Kbyte region of 32 pages
// - erase or program into locked region aborts and raises interrupt
// - set-lock sets a region bit, clear-lock clears it
// - valid erase pin clears every lock bit
// - security set refuses debug port and fast port flash access; full erase commands from either port still run
// - software only sets security; erase pin plus full erase clears it
// - calibration bits are fixed and untouched by erase pin
// - fast port accepts read, program, erase, full erase, lock, unlock, protect
// - 128-byte write buffer loaded 32 bits at a time; 256-byte pages
// - a register read returns the flash organisation descriptor
// - flash read 128 bits wide, presented as 32-bit words
// - erase pin debounced on slow clock: under 100 ms ignored, over 220 ms acts
package memmap_pkg;
  localparam logic [31:0] ZERO_BASE    = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE   = 32'h0010_0000;
  localparam logic [31:0] CORE_BASE    = 32'h0020_0000;
  localparam logic [31:0] BACKUP_BASE  = 32'h0030_0000;
  localparam logic [31:0] CONTIG_BASE  = 32'h002F_F000;
  localparam logic [31:0] ROM_BASE     = 32'h0040_0000;
  localparam logic [31:0] AREA_SIZE    = 32'h0010_0000;
  localparam logic [31:0] INT_LIMIT    = 32'h1000_0000;
  localparam logic [31:0] CORE_SIZE    = 32'h0000_1000;
  localparam logic [31:0] BACKUP_SIZE  = 32'h0000_0800;
  localparam logic [31:0] ROM_SIZE     = 32'h0000_3000;
  localparam logic [31:0] FLASH_SIZE   = 32'h0002_0000;
  localparam int          SLOW_HZ      = 32768;
  localparam int          ERASE_IGN_MS = 100;
  localparam int          ERASE_ACT_MS = 220;
  localparam int          ERASE_IGN_CYC = (SLOW_HZ * ERASE_IGN_MS) / 1000;
  localparam int          ERASE_ACT_CYC = (SLOW_HZ * ERASE_ACT_MS + 999) / 1000 + 1;
  localparam int          PAGE_BYTES   = 256;
  localparam int          REGION_PAGES = 32;
  localparam int          WBUF_WORDS   = 32;
  localparam int          SEC_BIT      = 0;
  localparam int          BOOT_BIT     = 1;
  // flash controller command codes
  localparam logic [3:0] CMD_NONE   = 4'h0;
  localparam logic [3:0] CMD_PROG   = 4'h1;
  localparam logic [3:0] CMD_ERASE  = 4'h2;
  localparam logic [3:0] CMD_FULL   = 4'h3;
  localparam logic [3:0] CMD_SLOCK  = 4'h4;
  localparam logic [3:0] CMD_CLOCK  = 4'h5;
  localparam logic [3:0] CMD_SGP    = 4'h6;
  localparam logic [3:0] CMD_CGP    = 4'h7;
  localparam logic [3:0] CMD_DESC   = 4'h8;
  localparam logic [3:0] CMD_READ   = 4'h9;
  // APB register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LOCK   = 8'h0C;
  localparam logic [7:0] REG_GPBITS = 8'h10;
  localparam logic [7:0] REG_DESC   = 8'h14;
  localparam logic [7:0] REG_WBUF   = 8'h18;
  localparam logic [7:0] REG_CAL    = 8'h1C;
  localparam int CMD_LSB  = 0;
  localparam int ARG_LSB  = 8;
  localparam int PORT_LSB = 24;
  // command source
  localparam logic [1:0] SRC_CPU  = 2'h0;
  localparam logic [1:0] SRC_ICE  = 2'h1;
  localparam logic [1:0] SRC_FAST = 2'h2;
  typedef enum logic [3:0] {
    SEL_NONE  = 4'b0001,
    SEL_ROM   = 4'b0010,
    SEL_FLASH = 4'b0100,
    SEL_SRAM  = 4'b1000
  } target_e;
endpackage : memmap_pkg
